// *** bench/acc_properties.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// bus answer and conversion start checks, top ports only
module acc_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic [4:0] channel_select_o,
	input wire logic busy_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req, wr, sc_wr, rd_res;
	logic [4:0] ch_q;
	logic [1:0] mode_q;
	// a write lands at the edge where ack is sampled
	assign req = wb_cyc_i && wb_stb_i;
	assign wr = wb_ack_o && req && wb_we_i && wb_sel_i[0];
	assign sc_wr = wr && wb_adr_i == 32'hf0;
	assign rd_res = wb_ack_o && req && !wb_we_i && (wb_adr_i == 32'hf4 || wb_adr_i == 32'hf8);
	// mode shadow: hardware-trigger and reserved modes ignore status writes as a start
	always_ff @(posedge clk_i) begin
		ch_q <= wb_dat_i[4:0];
		if (rst_i)
			mode_q <= 2'h0;
		else if (wr && wb_adr_i == 32'hfc)
			mode_q <= wb_dat_i[3:2];
	end
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held past one cycle");
	property p_answer; req && !wb_ack_o && !wb_err_o |=> wb_ack_o || wb_err_o; endproperty
	a_answer: assert property (p_answer) else $error("request not answered next cycle");
	property p_err; req && !wb_ack_o && !wb_err_o && wb_adr_i > 32'h108 |=> wb_err_o && !wb_ack_o; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_start; sc_wr && wb_dat_i[4:0] != 5'h1f && !mode_q[1] |-> ##[1:2] busy_o; endproperty
	a_start: assert property (p_start) else $error("status write did not start");
	property p_no_start; sc_wr && wb_dat_i[4:0] == 5'h1f |-> ##2 !busy_o; endproperty
	a_no_start: assert property (p_no_start) else $error("channel off still converting");
	property p_chan; sc_wr |=> channel_select_o == ch_q; endproperty
	a_chan: assert property (p_chan) else $error("channel output not updated");
	property p_irq_w; sc_wr |-> ##2 !irq_o; endproperty
	a_irq_w: assert property (p_irq_w) else $error("irq kept after status write");
	property p_irq_r; rd_res |-> ##2 !irq_o; endproperty
	a_irq_r: assert property (p_irq_r) else $error("irq kept after result read");
	c_irq: cover property ($rose(irq_o));
	c_err: cover property (wb_err_o);
	c_start: cover property (sc_wr ##1 busy_o);
endmodule : acc_properties
bind acc_conv_ctrl acc_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.channel_select_o(channel_select_o), .busy_o(busy_o), .irq_o(irq_o));

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, alt_clk_i, hw_trigger_i, stop_mode_i, er;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
	logic [3:0] wb_sel_i;
	logic [9:0] conv_data_i;
	logic [4:0] channel_select_o;
	logic wb_ack_o, wb_err_o, converter_clock_o, low_power_config_o, sample_o, busy_o, irq_o;
	int n_mismatch = 0;
	int tests_run = 0;
	int c, n;
	typedef struct {logic [31:0] a; logic [31:0] d; logic e;} acc_row_t;
	acc_row_t rows[8];
	logic [31:0] cfg[5] = '{32'h10, 32'h30, 32'h50, 32'h70, 32'h00};
	int r[5] = '{1, 2, 4, 8, 2};
	acc_conv_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .alt_clk_i(alt_clk_i),
		.hw_trigger_i(hw_trigger_i), .stop_mode_i(stop_mode_i), .conv_data_i(conv_data_i),
		.channel_select_o(channel_select_o), .converter_clock_o(converter_clock_o),
		.low_power_config_o(low_power_config_o), .sample_o(sample_o), .busy_o(busy_o), .irq_o(irq_o));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// alternate source: one rising edge every two bus cycles
	always @(posedge clk_i) alt_clk_i <= ~alt_clk_i;
	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// classic cycle: ack sampled at the rising edge, request released there; returns on a falling edge
	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		wb_adr_i <= a;
		wb_we_i <= w;
		wb_dat_i <= d;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && i < 20);
		if (i >= 20) begin
			n_mismatch++;
			end_of_test();
		end
		rd = wb_dat_o;
		er = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(negedge clk_i);
	endtask : bus
	// bounded wait for busy to reach a level, cycles counted in c
	task automatic wt(input logic v);
		c = 0;
		while (busy_o !== v && c < 2000) begin
			@(negedge clk_i);
			c++;
		end
		if (c >= 2000) begin
			n_mismatch++;
			end_of_test();
		end
	endtask : wt
	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
		bus(a, 1'b0, 32'h0);
		chk("readback", exp, rd);
	endtask : rdchk
	////////////////////////////////////////////////////////////////
	initial begin
		{rst_i, wb_we_i, wb_cyc_i, wb_stb_i} = 4'h8;
		{wb_adr_i, wb_dat_i} = 64'h0;
		{alt_clk_i, hw_trigger_i, stop_mode_i} = 3'h0;
		wb_sel_i = 4'hf;
		conv_data_i = 10'h2a5;
		rows = '{'{32'hf0, 32'h1f, 0}, '{32'hf4, 0, 0}, '{32'hf8, 0, 0}, '{32'hfc, 0, 0},
			'{32'h100, 0, 0}, '{32'h104, 32'h1, 0}, '{32'h108, 0, 0}, '{32'h10c, 0, 1}};
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[k]) begin
			bus(rows[k].a, 1'b0, 32'h0);
			chk("reset value", rows[k].d, rd);
			chk("refusal", {31'h0, rows[k].e}, {31'h0, er});
		end
		$display("test reset done");
		// 8-bit software mode with interrupt enabled
		bus(32'hfc, 1'b1, 32'h10);
		bus(32'hf0, 1'b1, 32'h43);
		wt(1'b0);
		chk("irq", 1, irq_o);
		rdchk(32'hf0, 32'hc3);
		rdchk(32'hf4, 32'h0);
		rdchk(32'hf8, 32'ha9);
		chk("irq", 0, irq_o);
		rdchk(32'hf0, 32'h43);
		// 10-bit software, reserved, then hardware trigger
		bus(32'hfc, 1'b1, 32'h14);
		bus(32'hf0, 1'b1, 32'h03);
		wt(1'b0);
		rdchk(32'hf4, 32'h2);
		rdchk(32'hf8, 32'ha5);
		bus(32'hfc, 1'b1, 32'h18);
		bus(32'hf0, 1'b1, 32'h03);
		chk("busy", 0, busy_o);
		bus(32'hfc, 1'b1, 32'h1c);
		@(posedge clk_i) hw_trigger_i <= 1'b1;
		wt(1'b1);
		wt(1'b0);
		rdchk(32'hf4, 32'h2);
		@(posedge clk_i) hw_trigger_i <= 1'b0;
		$display("test modes done");
		// conversion length per divider and per source
		foreach (cfg[k]) begin
			bus(32'hfc, 1'b1, cfg[k]);
			bus(32'hf0, 1'b1, 32'h03);
			wt(1'b0);
			chk("length", 1, c >= 10 * r[k] - 3 && c <= 11 * r[k] + 6);
		end
		chk("int off", 0, irq_o);
		rdchk(32'h100, 32'h0);
		// abort by channel off
		bus(32'hfc, 1'b1, 32'h10);
		bus(32'hf0, 1'b1, 32'h03);
		bus(32'hf0, 1'b1, 32'h1f);
		chk("abort", 0, busy_o);
		chk("channel", 32'h1f, channel_select_o);
		// continuous runs until clock write, then until stop
		bus(32'hf0, 1'b1, 32'h23);
		n = 0;
		repeat (80) begin
			@(negedge clk_i);
			n += sample_o;
		end
		chk("repeats", 1, n >= 4);
		bus(32'hfc, 1'b1, 32'h10);
		rdchk(32'h108, 32'h0);
		bus(32'hf0, 1'b1, 32'h23);
		@(posedge clk_i) stop_mode_i <= 1'b1;
		repeat (8) @(negedge clk_i);
		chk("stop", 0, busy_o);
		@(posedge clk_i) stop_mode_i <= 1'b0;
		$display("test continuous done");
		// power bit, then masked interrupt and write-one-to-clear
		bus(32'hfc, 1'b1, 32'h90);
		chk("low power", 1, low_power_config_o);
		bus(32'hfc, 1'b1, 32'h10);
		chk("low power", 0, low_power_config_o);
		bus(32'h104, 1'b1, 32'h0);
		bus(32'hf0, 1'b1, 32'h43);
		wt(1'b0);
		chk("masked", 0, irq_o);
		rdchk(32'h100, 32'h1);
		bus(32'h100, 1'b1, 32'h1);
		rdchk(32'h100, 32'h0);
		$display("test interrupts done");
		end_of_test();
	end
endmodule : tb_top

// *** rtl/acc_clk_div.sv ***
`timescale 1ns/1ps
// converter clock tick generator: picks input clock and divides by 1/2/4/8
module acc_clk_div (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic restart_i,
	input wire logic alt_clk_i,
	input wire logic inclk_bus_i,
	input wire logic [1:0] div_i,
	output logic tick_o
);
	logic [2:0] alt_sync_q;
	logic src_tick;
	logic [2:0] cnt_q;
	logic [2:0] limit;

	////////////////////////////////////////////////////////////////
	// alternate clock is an outside level: three flops, edge when stages two and three differ rising
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alt_sync_q <= 3'h0;
		end else begin
			alt_sync_q <= {alt_sync_q[1:0], alt_clk_i};
		end
	end

	// bus clock ticks every cycle; alternate ticks once per its rising edge
	assign src_tick = inclk_bus_i ? 1'b1 : (alt_sync_q[1] & ~alt_sync_q[2]);
	assign limit = 3'((4'h1 << div_i) - 4'h1);

	// divider counter, restarted so a conversion started by a status write gets a clean phase
	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i) begin
			cnt_q <= 3'h0;
			tick_o <= 1'b0;
		end else if (src_tick) begin
			tick_o <= (cnt_q == limit);
			cnt_q <= (cnt_q == limit) ? 3'h0 : 3'(cnt_q + 3'h1);
		end else begin
			tick_o <= 1'b0;
		end
	end
endmodule : acc_clk_div

// *** rtl/acc_conv_ctrl.sv ***
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
module acc_conv_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic alt_clk_i,
	input wire logic hw_trigger_i,
	input wire logic stop_mode_i,
	input wire logic [9:0] conv_data_i,
	output logic [4:0] channel_select_o,
	output logic converter_clock_o,
	output logic low_power_config_o,
	output logic sample_o,
	output logic busy_o,
	output logic irq_o
);
	logic [7:0] sc_q;
	logic [7:0] cc_q;
	logic [9:0] result_q;
	logic [1:0] irq_status_q;
	logic [1:0] irq_mask_q;
	logic busy_q;
	logic [4:0] tick_cnt_q;
	logic [2:0] trig_sync_q;
	logic req;
	logic [7:0] idx;
	logic wr_sc;
	logic wr_cc;
	logic rd_low;
	logic rd_high;
	logic wr_lane0;
	logic done;
	logic start;
	logic trig_rise;
	logic stop_abort;
	logic [2:0] stop_sync_q;
	logic stop_q;
	logic sw_mode;
	logic mapped;
	logic tick;
	logic [4:0] conv_len;
	acc_pkg::acc_mode_t mode;

	////////////////////////////////////////////////////////////////
	// bus decode: one-cycle ack, word index from address bits 9:2
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign idx = wb_adr_i[9:2];
	assign wr_lane0 = req & wb_we_i & wb_sel_i[0];
	assign wr_sc = wr_lane0 && idx == acc_pkg::STATUS_CONTROL_IDX;
	assign wr_cc = wr_lane0 && idx == acc_pkg::CLOCK_CONFIG_IDX;
	assign rd_low = req && !wb_we_i && idx == acc_pkg::RESULT_LOW_IDX;
	assign rd_high = req && !wb_we_i && idx == acc_pkg::RESULT_HIGH_IDX;
	assign mapped = (wb_adr_i[31:10] == 22'h0) && (wb_adr_i[1:0] == 2'h0) &&
		(idx >= acc_pkg::STATUS_CONTROL_IDX) && (idx <= acc_pkg::CONV_DATA_IDX);
	assign mode = acc_pkg::acc_mode_t'(cc_q[acc_pkg::CC_MODE_LSB +: 2]);

	// read data mux; reserved and upper bits read zero
	function automatic logic [31:0] acc_read(input logic [7:0] i, input logic [7:0] sc, input logic [7:0] cc,
		input logic [9:0] res, input logic [1:0] ist, input logic [1:0] imk, input logic bsy);
		logic [31:0] r;
		r = 32'h0;
		unique case (i)
			acc_pkg::STATUS_CONTROL_IDX: r[7:0] = sc;
			acc_pkg::RESULT_HIGH_IDX: r[1:0] = res[9:8];
			acc_pkg::RESULT_LOW_IDX: r[7:0] = res[7:0];
			acc_pkg::CLOCK_CONFIG_IDX: r[7:0] = cc;
			acc_pkg::IRQ_STATUS_IDX: r[1:0] = ist;
			acc_pkg::IRQ_MASK_IDX: r[1:0] = imk;
			acc_pkg::CONV_DATA_IDX: r[0] = bsy;
			default: r = 32'h0;
		endcase
		return r;
	endfunction : acc_read

	// bus answer; unmapped addresses get err instead of ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req & mapped;
			wb_err_o <= req & ~mapped;
			wb_dat_o <= (req & mapped & ~wb_we_i) ?
				acc_read(idx, sc_q, cc_q, result_q, irq_status_q, irq_mask_q, busy_q) : 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////
	// hardware trigger pin: three flops, rising edge when stage two is high and stage three still low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trig_sync_q <= 3'h0;
		end else begin
			trig_sync_q <= {trig_sync_q[1:0], hw_trigger_i};
		end
	end
	assign trig_rise = trig_sync_q[1] & ~trig_sync_q[2];

	// stop mode is a pin level: three flops, the level moves only when stages two and three agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stop_sync_q <= 3'h0;
			stop_q <= 1'b0;
		end else begin
			stop_sync_q <= {stop_sync_q[1:0], stop_mode_i};
			if (stop_sync_q[1] == stop_sync_q[2]) begin
				stop_q <= stop_sync_q[2];
			end
		end
	end

	// stop mode halts conversion only while the async clock is off
	assign stop_abort = stop_q & ~cc_q[acc_pkg::CC_ASYNC_EN_BIT];

	// only the two software modes take a status write as a start; reserved and hardware modes do not
	assign sw_mode = (mode == acc_pkg::ACC_MODE_8_SW) || (mode == acc_pkg::ACC_MODE_10_SW);

	// start conditions per mode; channel all ones never starts
	always_comb begin
		start = 1'b0;
		if (sc_q[4:0] != acc_pkg::CHANNEL_OFF && !stop_abort) begin
			unique case (mode)
				acc_pkg::ACC_MODE_10_HW: start = trig_rise & ~busy_q;
				acc_pkg::ACC_MODE_RSVD: start = 1'b0;
				default: start = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// converter clock ticks; restart on any status or clock-config write so timing is fresh
	acc_clk_div u_div (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(wr_sc | wr_cc),
		.alt_clk_i(alt_clk_i),
		.inclk_bus_i(cc_q[acc_pkg::CC_INCLK_BIT]),
		.div_i(cc_q[acc_pkg::CC_DIV_LSB +: 2]),
		.tick_o(tick)
	);

	assign conv_len = cc_q[acc_pkg::CC_LONG_SAMPLE_BIT] ?
		5'(acc_pkg::CONV_TICKS + acc_pkg::LONG_SAMPLE_EXTRA) : 5'(acc_pkg::CONV_TICKS);
	// an aborted conversion never completes, so a write in the last tick cannot be outvoted by done
	assign done = busy_q && tick && (tick_cnt_q == conv_len - 5'h1) && !wr_sc && !wr_cc && !stop_abort;

	// conversion sequencer: a status or clock-config write always aborts what runs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
			tick_cnt_q <= 5'h0;
		end else if (wr_sc) begin
			busy_q <= (wb_dat_i[4:0] != acc_pkg::CHANNEL_OFF) && sw_mode;
			tick_cnt_q <= 5'h0;
		end else if (wr_cc || stop_abort) begin
			busy_q <= 1'b0;
			tick_cnt_q <= 5'h0;
		end else if (done) begin
			busy_q <= sc_q[acc_pkg::SC_CONT_BIT];
			tick_cnt_q <= 5'h0;
		end else if (start) begin
			busy_q <= 1'b1;
			tick_cnt_q <= 5'h0;
		end else if (busy_q && tick) begin
			tick_cnt_q <= 5'(tick_cnt_q + 5'h1);
		end
	end

	////////////////////////////////////////////////////////////////
	// status/control: write loads control bits, done sets complete (set wins)
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sc_q <= acc_pkg::STATUS_CONTROL_RST;
		end else begin
			if (wr_sc) begin
				sc_q[6:0] <= wb_dat_i[6:0];
			end
			if (done) begin
				sc_q[acc_pkg::SC_COMPLETE_BIT] <= 1'b1;
			end else if (wr_sc || rd_low) begin
				sc_q[acc_pkg::SC_COMPLETE_BIT] <= 1'b0;
			end
		end
	end

	// continuous stops on clock write through the sequencer abort; the continuous bit stays set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cc_q <= acc_pkg::CLOCK_CONFIG_RST;
		end else if (wr_cc) begin
			cc_q <= wb_dat_i[7:0];
		end
	end

	// results: 8-bit mode keeps upper bits zero, both right-justified
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_q <= 10'h0;
		end else if (done) begin
			result_q <= (mode == acc_pkg::ACC_MODE_8_SW) ? {2'h0, conv_data_i[9:2]} : conv_data_i;
		end
	end

	////////////////////////////////////////////////////////////////
	// sticky interrupt status; conversion done only counts while enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_status_q <= 2'h0;
		end else begin
			if (done && sc_q[acc_pkg::SC_IRQ_EN_BIT]) begin
				irq_status_q[acc_pkg::IRQ_DONE_BIT] <= 1'b1;
			end else if (wr_sc || rd_low || rd_high ||
				(wr_lane0 && idx == acc_pkg::IRQ_STATUS_IDX && wb_dat_i[acc_pkg::IRQ_DONE_BIT])) begin
				irq_status_q[acc_pkg::IRQ_DONE_BIT] <= 1'b0;
			end
			if (trig_rise && busy_q && mode == acc_pkg::ACC_MODE_10_HW) begin
				irq_status_q[acc_pkg::IRQ_TRIG_LOST_BIT] <= 1'b1;
			end else if (wr_lane0 && idx == acc_pkg::IRQ_STATUS_IDX && wb_dat_i[acc_pkg::IRQ_TRIG_LOST_BIT]) begin
				irq_status_q[acc_pkg::IRQ_TRIG_LOST_BIT] <= 1'b0;
			end
		end
	end

	// mask register: 1 lets the event reach irq_o
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_q <= 2'h1;
		end else if (wr_lane0 && idx == acc_pkg::IRQ_MASK_IDX) begin
			irq_mask_q <= wb_dat_i[1:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs straight from flops; irq lags status by one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			channel_select_o <= acc_pkg::STATUS_CONTROL_RST[4:0];
			converter_clock_o <= 1'b0;
			low_power_config_o <= 1'b0;
			sample_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status_q & irq_mask_q);
			channel_select_o <= sc_q[4:0];
			converter_clock_o <= tick & busy_q;
			low_power_config_o <= cc_q[acc_pkg::CC_LOW_POWER_BIT];
			sample_o <= done;
			busy_o <= busy_q;
		end
	end
endmodule : acc_conv_ctrl

// *** rtl/acc_pkg.sv ***
package acc_pkg;
	// register offsets (printed offsets are not multiples of four: these are indices, byte address is 4x)
	localparam logic [7:0] STATUS_CONTROL_IDX = 8'h3c;
	localparam logic [7:0] RESULT_HIGH_IDX = 8'h3d;
	localparam logic [7:0] RESULT_LOW_IDX = 8'h3e;
	localparam logic [7:0] CLOCK_CONFIG_IDX = 8'h3f;
	localparam logic [7:0] IRQ_STATUS_IDX = 8'h40;
	localparam logic [7:0] IRQ_MASK_IDX = 8'h41;
	localparam logic [7:0] CONV_DATA_IDX = 8'h42;
	// reset values
	localparam logic [7:0] STATUS_CONTROL_RST = 8'h1f;
	localparam logic [7:0] CLOCK_CONFIG_RST = 8'h00;
	// status/control fields
	localparam int SC_COMPLETE_BIT = 7;
	localparam int SC_IRQ_EN_BIT = 6;
	localparam int SC_CONT_BIT = 5;
	localparam logic [4:0] CHANNEL_OFF = 5'h1f;
	// clock config fields
	localparam int CC_LOW_POWER_BIT = 7;
	localparam int CC_DIV_LSB = 5;
	localparam int CC_INCLK_BIT = 4;
	localparam int CC_MODE_LSB = 2;
	localparam int CC_LONG_SAMPLE_BIT = 1;
	localparam int CC_ASYNC_EN_BIT = 0;
	// interrupt status bits
	localparam int IRQ_DONE_BIT = 0;
	localparam int IRQ_TRIG_LOST_BIT = 1;
	// conversion timing in converter clock ticks
	localparam int CONV_TICKS = 10;
	localparam int LONG_SAMPLE_EXTRA = 4;
	typedef enum logic [1:0] {
		ACC_MODE_8_SW = 2'h0,
		ACC_MODE_10_SW = 2'h1,
		ACC_MODE_RSVD = 2'h2,
		ACC_MODE_10_HW = 2'h3
	} acc_mode_t;
endpackage : acc_pkg
